//--- verilog/pocs_pkg.sv
// package: register map, field layout and encodings of the overcurrent source bank
package pocs_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int unsigned NUM_PORTS  = 5;
    localparam int unsigned FIRST_PORT = 3;
    localparam int unsigned ADDR_W     = 16;
    localparam int unsigned DATA_W     = 8;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] PORT3_OVERCURRENT_SOURCE_ADDR = 16'h3C28;
    localparam logic [15:0] PORT4_OVERCURRENT_SOURCE_ADDR = 16'h3C2C;
    localparam logic [15:0] PORT5_OVERCURRENT_SOURCE_ADDR = 16'h3C30;
    localparam logic [15:0] PORT6_OVERCURRENT_SOURCE_ADDR = 16'h3C34;
    localparam logic [15:0] PORT7_OVERCURRENT_SOURCE_ADDR = 16'h3C38;
    localparam logic [15:0] PORT_STRIDE                   = 16'h0004;
    // interrupt block
    localparam logic [15:0] IRQ_STATUS_ADDR               = 16'h3C40;
    localparam logic [15:0] IRQ_MASK_ADDR                 = 16'h3C44;
    localparam logic [15:0] OC_LEVEL_ADDR                 = 16'h3C48;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned SRC_LSB = 0;
    localparam int unsigned SRC_W   = 4;
    localparam logic [7:0] SRC_RESET  = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------------
    // source encodings
    // ------------------------------------------------------------------
    localparam logic [3:0] SRC_DISABLED = 4'h0;
    localparam logic [3:0] SRC_PIN      = 4'h1;
    localparam logic [3:0] SRC_GPIO     = 4'h2;
    localparam logic [3:0] SRC_FORCE    = 4'hF;

    // register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } pocs_bus_req_t;

    // per-port sense inputs
    typedef struct packed {
        logic [4:0] sense;
        logic [4:0] gpio;
    } pocs_sense_t;

endpackage

//--- verilog/pocs_port_mux.sv
// one port's overcurrent source multiplexer
`timescale 1ns/10ps
module pocs_port_mux (
    input  wire logic [3:0] source_i,
    input  wire logic       sense_i,
    input  wire logic       gpio_i,
    output logic            overcurrent_o
);

    // ------------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------------
    // reserved codes fall to inactive: a stray code never trips a port
    always_comb begin
        case (source_i)
            pocs_pkg::SRC_DISABLED: overcurrent_o = 1'b0;
            pocs_pkg::SRC_PIN:      overcurrent_o = sense_i;
            pocs_pkg::SRC_GPIO:     overcurrent_o = gpio_i;
            pocs_pkg::SRC_FORCE:    overcurrent_o = 1'b1;
            default:                overcurrent_o = 1'b0;
        endcase
    end

endmodule

//--- verilog/pocs_bank.sv
// overcurrent source select register bank for downstream ports 3 to 7
// Summary of operation
// - Ports 3 to 7 own byte registers from 0x3C28, four apart; bits 3:0 pick the source.
// - Code 0000b disables the port so no overcurrent is taken for it.
// - Code 0001b takes the port's overcurrent from its own sense pin.
// - Code 0010b takes the port's overcurrent from a general-purpose input.
// - Code 1111b forces the port's overcurrent active for test.
`timescale 1ns/10ps
module pocs_bank #(
    parameter int unsigned NUM_PORTS = pocs_pkg::NUM_PORTS
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire logic [15:0]          addr_i,
    input  wire logic [7:0]           wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [7:0]           rdata_o,
    input  wire logic [NUM_PORTS-1:0] overcurrent_sense_i,
    input  wire logic [NUM_PORTS-1:0] gpio_i,
    output logic      [NUM_PORTS-1:0] overcurrent_o,
    output logic                      irq_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PORTS-1:0][3:0] src;
        logic [NUM_PORTS-1:0]      oc_q;
        logic [NUM_PORTS-1:0]      status;
        logic [NUM_PORTS-1:0]      mask;
        logic [7:0]                rdata;
    } pocs_state_t;

    pocs_state_t          st;
    pocs_state_t          next_st;
    logic [NUM_PORTS-1:0] oc_now;
    logic [NUM_PORTS-1:0] oc_rise;

    // address of a port's register: base plus stride per port
    function automatic logic [15:0] port_addr(input int unsigned idx);
        port_addr = pocs_pkg::PORT3_OVERCURRENT_SOURCE_ADDR
                  + 16'(idx) * pocs_pkg::PORT_STRIDE;
    endfunction

    // widen a per-port vector into a byte
    function automatic logic [7:0] to_byte(input logic [NUM_PORTS-1:0] v);
        logic [7:0] b;
        b = 8'h00;
        b[NUM_PORTS-1:0] = v;
        to_byte = b;
    endfunction

    // ------------------------------------------------------------------
    // per-port source multiplexers
    // ------------------------------------------------------------------
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        pocs_port_mux u_mux (
            .source_i      (st.src[p]),
            .sense_i       (overcurrent_sense_i[p]),
            .gpio_i        (gpio_i[p]),
            .overcurrent_o (oc_now[p])
        );
    end

    assign oc_rise = oc_now & ~st.oc_q;

    // ------------------------------------------------------------------
    // next state: register writes, reads, interrupt status
    // ------------------------------------------------------------------
    // a rising overcurrent sets its status bit; set wins over a
    // write-one clear in the same cycle so no event is lost
    always_comb begin
        next_st       = st;
        next_st.oc_q  = oc_now;
        next_st.rdata = 8'h00;
        if (wr_i) begin
            for (int unsigned p = 0; p < NUM_PORTS; p++) begin
                if (addr_i == port_addr(p)) begin
                    // upper nibble dropped on write
                    next_st.src[p] = wdata_i[pocs_pkg::SRC_LSB +: pocs_pkg::SRC_W];
                end
            end
            if (addr_i == pocs_pkg::IRQ_STATUS_ADDR) begin
                next_st.status = st.status & ~wdata_i[NUM_PORTS-1:0];
            end else if (addr_i == pocs_pkg::IRQ_MASK_ADDR) begin
                next_st.mask = wdata_i[NUM_PORTS-1:0];
            end
        end
        next_st.status = next_st.status | oc_rise;
        if (rd_i) begin
            next_st.rdata = pocs_pkg::UNMAPPED_READ;
            for (int unsigned p = 0; p < NUM_PORTS; p++) begin
                if (addr_i == port_addr(p)) begin
                    next_st.rdata = {4'h0, st.src[p]};
                end
            end
            if (addr_i == pocs_pkg::IRQ_STATUS_ADDR) begin
                next_st.rdata = to_byte(st.status);
            end else if (addr_i == pocs_pkg::IRQ_MASK_ADDR) begin
                next_st.rdata = to_byte(st.mask);
            end else if (addr_i == pocs_pkg::OC_LEVEL_ADDR) begin
                next_st.rdata = to_byte(st.oc_q);
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // configuration is meant to be static after load; a later write
    // still takes effect at once, with no glitch protection
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_o       = st.rdata;
    assign overcurrent_o = st.oc_q;
    assign irq_o         = |(st.status & st.mask);

endmodule

//--- testbench/pocs_checker.sv
// checker: port properties of the overcurrent source bank
`timescale 1ns/10ps
module pocs_checker #(parameter int unsigned NUM_PORTS = 5) (
    input wire logic                 clk_sys_i,
    input wire logic                 rst_n_i,
    input wire logic [15:0]          addr_i,
    input wire logic [7:0]           wdata_i,
    input wire logic                 wr_i,
    input wire logic                 rd_i,
    input wire logic [7:0]           rdata_o,
    input wire logic [NUM_PORTS-1:0] overcurrent_sense_i,
    input wire logic [NUM_PORTS-1:0] gpio_i,
    input wire logic [NUM_PORTS-1:0] overcurrent_o,
    input wire logic                 irq_o
);
    logic [3:0]           sh [NUM_PORTS];
    logic [NUM_PORTS-1:0] dis, pin, gpo, frc;
    logic                 hit;
    logic [2:0]           idx;
    assign hit = addr_i >= 16'h3C28 && addr_i <= 16'h3C38 && addr_i[1:0] == 2'h0;
    assign idx = addr_i[4:2] - 3'h2;
    // shadow of the source fields, so outputs can be judged without the bodies
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                sh[p] <= 4'h0;
            end
        end else if (wr_i && hit) begin
            sh[idx] <= wdata_i[3:0];
        end
    end
    // decoded source per port
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            dis[p] = sh[p] == 4'h0;
            pin[p] = sh[p] == 4'h1;
            gpo[p] = sh[p] == 4'h2;
            frc[p] = sh[p] == 4'hF;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    property p_dis; 1 |=> (overcurrent_o & $past(dis)) == '0; endproperty
    property p_pin; 1 |=> (overcurrent_o & $past(pin)) == $past(overcurrent_sense_i & pin);
    endproperty
    property p_gpio; 1 |=> (overcurrent_o & $past(gpo)) == $past(gpio_i & gpo); endproperty
    property p_frc; 1 |=> (overcurrent_o & $past(frc)) == $past(frc); endproperty
    property p_rd; rd_i && hit |=> rdata_o[3:0] == $past(sh[idx]); endproperty
    property p_hi; rd_i && hit |=> rdata_o[7:4] == 4'h0; endproperty
    property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
    property p_unm; rd_i && addr_i == 16'h3C3C |=> rdata_o == 8'h00; endproperty
    a_dis: assert property (p_dis) else $error("disabled port shows overcurrent");
    a_pin: assert property (p_pin) else $error("port ignores its sense pin");
    a_gpio: assert property (p_gpio) else $error("port ignores its gpio");
    a_frc: assert property (p_frc) else $error("forced port not active");
    a_rd: assert property (p_rd) else $error("source field readback wrong");
    a_hi: assert property (p_hi) else $error("reserved bits not zero");
    a_idle: assert property (p_idle) else $error("read data without read");
    a_unm: assert property (p_unm) else $error("gap address reads nonzero");
    c_rd: cover property (rd_i && hit);
    c_irq: cover property (irq_o);
    c_oc: cover property ($rose(overcurrent_o[0]));
endmodule
bind pocs_bank pocs_checker #(.NUM_PORTS(NUM_PORTS)) i_chk (.clk_sys_i, .rst_n_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .overcurrent_sense_i, .gpio_i, .overcurrent_o, .irq_o);

//--- testbench/pocs_switch_model.sv
// model of the external power switches reporting overcurrent
`timescale 1ns/10ps
module pocs_switch_model (
    input  wire logic [4:0] trip_i,
    input  wire logic [4:0] alt_i,
    output logic      [4:0] sense_o,
    output logic      [4:0] gpio_o
);
    // flags are driven levels, never released, so no floating state
    assign sense_o = trip_i;
    assign gpio_o = alt_i;
endmodule

//--- testbench/pocs_bank_tb.sv
// self-checking bench for the overcurrent source bank
`timescale 1ns/10ps
module pocs_bank_tb;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [7:0]  rdata_o;
    logic [4:0]  trip = 5'h15;
    logic [4:0]  alt = 5'h0A;
    logic [4:0]  sense, gpio, oc, exp;
    logic        irq;
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    logic [3:0]  codes [4] = '{4'h0, 4'h1, 4'h2, 4'hF};
    pocs_switch_model i_sw (.trip_i(trip), .alt_i(alt), .sense_o(sense), .gpio_o(gpio));
    pocs_bank i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .overcurrent_sense_i(sense), .gpio_i(gpio), .overcurrent_o(oc), .irq_o(irq));
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        tests_run++;
        if (got !== want) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [15:0] a, input logic [7:0] want);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, want);
    endtask
    // pulse reset so that each configuration is loaded once, as at start-up
    task automatic restart;
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // hang guard: the sequence needs under two hundred cycles
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            stop_test();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (int p = 0; p < 5; p++) rd(16'h3C28 + 16'(4 * p), 8'h00);
        wr(16'h3C3C, 8'hFF);
        rd(16'h3C3C, 8'h00);
        $display("test reset and gap done");
        // every defined code on every port, each loaded once after a reset;
        // upper nibble written as ones to prove it is dropped
        for (int c = 0; c < 4; c++) begin
            restart();
            rd(16'h3C28, 8'h00);
            for (int p = 0; p < 5; p++) begin
                wr(16'h3C28 + 16'(4 * p), {4'hF, codes[c]});
            end
            repeat (2) @(posedge clk_sys_i);
            #1;
            exp = (c == 0) ? 5'h00 : (c == 1) ? trip : (c == 2) ? alt : 5'h1F;
            chk({3'h0, oc}, {3'h0, exp});
            for (int p = 0; p < 5; p++) rd(16'h3C28 + 16'(4 * p), {4'h0, codes[c]});
            $display("test code %h done", codes[c]);
        end
        // interrupt: ports follow their sense pins; only the pins move after loading
        restart();
        trip <= 5'h14;
        for (int p = 0; p < 5; p++) wr(16'h3C28 + 16'(4 * p), 8'h01);
        wr(16'h3C40, 8'h1F);
        wr(16'h3C44, 8'h01);
        rd(16'h3C40, 8'h00);
        @(posedge clk_sys_i);
        trip <= 5'h15;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk({7'h0, irq}, 8'h01);
        rd(16'h3C48, 8'h15);
        rd(16'h3C40, 8'h01);
        wr(16'h3C44, 8'h00);
        #1;
        chk({7'h0, irq}, 8'h00);
        wr(16'h3C40, 8'h01);
        rd(16'h3C40, 8'h00);
        // a rise in the same cycle as its clear must leave the bit set
        @(posedge clk_sys_i);
        trip <= 5'h14;
        repeat (2) @(posedge clk_sys_i);
        fork
            wr(16'h3C40, 8'h01);
            begin
                @(posedge clk_sys_i);
                trip <= 5'h15;
            end
        join
        rd(16'h3C40, 8'h01);
        $display("test interrupt done");
        stop_test();
    end
endmodule
